// ### src/plmb_pkg.sv
package plmb_pkg;

    // array shape
    localparam int BLK_NUM = 4;
    localparam int MC_NUM = 16;
    localparam int IN_NUM = 26;
    localparam int LT_NUM = 64;
    localparam int SP_NUM = 6;
    localparam int PT_NUM = LT_NUM + SP_NUM;
    localparam int CL_SZ = 4;
    localparam int CL_NUM = LT_NUM / CL_SZ;
    localparam int MAX_PT = 3 * CL_SZ;
    localparam int BANK_SZ = 8;
    localparam int OE_PER_BANK = 2;
    localparam int TERM_W = 2 * IN_NUM;

    // pins and routing sources
    localparam int IO_NUM = BLK_NUM * MC_NUM;
    localparam int DED_NUM = 2;
    localparam int CLK_NUM = 4;
    localparam int SRC_PIN = 0;
    localparam int SRC_MC = IO_NUM;
    localparam int SRC_DED = 2 * IO_NUM;
    localparam int SRC_CLK = SRC_DED + DED_NUM;
    localparam int SRC_NUM = SRC_CLK + CLK_NUM;
    localparam int SEL_W = 8;
    localparam logic [SEL_W-1:0] SRC_LIM = 8'h86;

    // special product terms
    localparam int PT_OE_BASE = LT_NUM;
    localparam int PT_RESET = LT_NUM + 4;
    localparam int PT_PRESET = LT_NUM + 5;

    // macrocell configuration word
    localparam int MCW = 11;
    localparam int MC_CL_LO = 0;
    localparam int MC_CL_W = 3;
    localparam int MC_REG = 3;
    localparam int MC_TTYPE = 4;
    localparam int MC_POL = 5;
    localparam int MC_CK_LO = 6;
    localparam int MC_OE_LO = 8;
    localparam int MC_OE_SEL = 10;

    typedef enum logic [1:0] {
        PLMB_OE_OFF = 2'h0,
        PLMB_OE_ON = 2'h1,
        PLMB_OE_PT = 2'h2
    } plmb_oe_e;

    // register port map
    localparam int ADDR_W = 11;
    localparam int DATA_W = 32;
    localparam int STAT_BIT = 10;
    localparam int BLK_LO = 8;
    localparam int IDX_W = 8;
    localparam logic [IDX_W-1:0] TERM_OFS = 8'h00;
    localparam logic [IDX_W-1:0] ROUTE_OFS = 8'h8C;
    localparam logic [IDX_W-1:0] MCFG_OFS = 8'hA6;
    localparam logic [IDX_W-1:0] MCFG_END = 8'hB6;
    localparam logic [IDX_W-1:0] STAT_PIN = 8'h00;
    localparam logic [IDX_W-1:0] STAT_SPT = 8'h01;
    localparam int TERM_LO_W = 32;

    // reset values
    localparam logic [TERM_W-1:0] TERM_RST = 52'h0;
    localparam logic [SEL_W-1:0] ROUTE_RST = 8'hFF;
    localparam logic [MCW-1:0] MCFG_RST = 11'h000;

endpackage : plmb_pkg

// ### src/plmb_pterm.sv
// one product term per row: AND of the literals its mask selects
module plmb_pterm
    import plmb_pkg::*;
(
    // routed block inputs
    input wire logic [IN_NUM-1:0] blk_in,
    // literal masks, bit 2i true input i, bit 2i+1 its complement
    input wire logic [PT_NUM-1:0][TERM_W-1:0] mask,
    // product terms
    output logic [PT_NUM-1:0] term
);

    logic [TERM_W-1:0] lit;

    always_comb
    begin
        for (int i = 0; i < IN_NUM; i++)
        begin
            lit[2*i] = blk_in[i];
            lit[2*i+1] = ~blk_in[i];
        end
    end

    // an empty mask gives a dead term rather than a constant one
    genvar p;
    generate
        for (p = 0; p < PT_NUM; p++)
        begin : g_pt
            assign term[p] = (|mask[p]) & (&(~mask[p] | lit));
        end
    endgenerate

endmodule : plmb_pterm

// ### src/plmb_mcell_bank.sv
// sixteen macrocells of one block
module plmb_mcell_bank
    import plmb_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // allocator sums and configuration
    input wire logic [MC_NUM-1:0] sum,
    input wire logic [MC_NUM-1:0][MCW-1:0] mcfg,
    // rising edges of the global clock pins
    input wire logic [CLK_NUM-1:0] ck_rise,
    // block reset and preset terms
    input wire logic rst_pt,
    input wire logic pre_pt,
    // macrocell values after polarity
    output logic [MC_NUM-1:0] mc_out
);

    typedef struct packed {
        logic [MC_NUM-1:0] q;
        logic [MC_NUM-1:0] out;
    } plmb_mc_s;

    plmb_mc_s cur_ff;
    plmb_mc_s nxt_ff;

    always_comb
    begin
        nxt_ff = cur_ff;
        for (int m = 0; m < MC_NUM; m++)
        begin
            if (rst_pt)
                nxt_ff.q[m] = 1'b0;
            else if (pre_pt)
                nxt_ff.q[m] = 1'b1;
            else if (ck_rise[mcfg[m][MC_CK_LO +: 2]])
            begin
                if (mcfg[m][MC_TTYPE])
                    nxt_ff.q[m] = cur_ff.q[m] ^ sum[m];
                else
                    nxt_ff.q[m] = sum[m];
            end
            // combinational cells are still sampled each mclk to break loops
            if (mcfg[m][MC_REG])
                nxt_ff.out[m] = nxt_ff.q[m] ^ mcfg[m][MC_POL];
            else
                nxt_ff.out[m] = sum[m] ^ mcfg[m][MC_POL];
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            cur_ff <= '0;
        else
            cur_ff <= nxt_ff;
    end

    assign mc_out = cur_ff.out;

endmodule : plmb_mcell_bank

// ### src/plmb_top.sv
// Local design decisions: the register offsets and the strobed register port.
module plmb_top
    import plmb_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // configuration port
    input wire logic [ADDR_W-1:0] cfg_addr,
    input wire logic [DATA_W-1:0] cfg_wdata,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    output logic [DATA_W-1:0] cfg_rdata,
    // pins
    input wire logic [IO_NUM-1:0] io_in,
    output logic [IO_NUM-1:0] io_out,
    output logic [IO_NUM-1:0] io_oe,
    input wire logic [DED_NUM-1:0] ded_in,
    input wire logic [CLK_NUM-1:0] gclk_in
);

    typedef struct packed {
        logic [BLK_NUM-1:0][PT_NUM-1:0][TERM_W-1:0] term;
        logic [BLK_NUM-1:0][IN_NUM-1:0][SEL_W-1:0] route;
        logic [BLK_NUM-1:0][MC_NUM-1:0][MCW-1:0] mcfg;
        logic [IO_NUM-1:0] io_s1;
        logic [IO_NUM-1:0] io_s2;
        logic [DED_NUM-1:0] ded_s1;
        logic [DED_NUM-1:0] ded_s2;
        logic [CLK_NUM-1:0] ck_s1;
        logic [CLK_NUM-1:0] ck_s2;
        logic [CLK_NUM-1:0] ck_prev;
        logic [IO_NUM-1:0] oe;
        logic [DATA_W-1:0] rdata;
    } plmb_top_s;

    plmb_top_s cur_ff;
    plmb_top_s nxt_ff;

    logic [SRC_NUM-1:0] src;
    logic [IO_NUM-1:0] mc_q;
    logic [CLK_NUM-1:0] ck_rise;
    logic [BLK_NUM-1:0][IN_NUM-1:0] blk_in;
    logic [BLK_NUM-1:0][PT_NUM-1:0] term;
    logic [BLK_NUM-1:0][CL_NUM-1:0] csum;
    logic [BLK_NUM-1:0][MC_NUM-1:0] sum;

    logic [BLK_LO-1:0] idx;
    logic [1:0] blk;
    logic [6:0] tidx;
    logic [IDX_W-1:0] ridx;
    logic [IDX_W-1:0] midx;

    assign idx = cfg_addr[BLK_LO-1:0];
    assign blk = cfg_addr[STAT_BIT-1:BLK_LO];
    assign tidx = idx[IDX_W-1:1];
    assign ridx = idx - ROUTE_OFS;
    assign midx = idx - MCFG_OFS;

    // pin and clock levels seen by the array only after two flops
    assign src = {cur_ff.ck_s2, cur_ff.ded_s2, mc_q, cur_ff.io_s2};
    assign ck_rise = cur_ff.ck_s2 & ~cur_ff.ck_prev;

    genvar b;
    genvar i;
    genvar m;
    generate
        for (b = 0; b < BLK_NUM; b++)
        begin : g_blk
            // unused route slots read a selector past the last source
            for (i = 0; i < IN_NUM; i++)
            begin : g_rt
                assign blk_in[b][i] = (cur_ff.route[b][i] < SRC_LIM) ?
                    src[cur_ff.route[b][i]] : 1'b0;
            end

            plmb_pterm u_pterm (
                .blk_in (blk_in[b]),
                .mask (cur_ff.term[b]),
                .term (term[b])
            );

            for (i = 0; i < CL_NUM; i++)
            begin : g_cl
                assign csum[b][i] = |term[b][i*CL_SZ +: CL_SZ];
            end

            // each cell reaches three clusters at most, so 12 terms at most
            for (m = 0; m < MC_NUM; m++)
            begin : g_alloc
                logic lo_c;
                logic mid_c;
                logic hi_c;
                if (m == 0)
                begin : g_first
                    assign lo_c = 1'b0;
                end
                else
                begin : g_lo
                    assign lo_c = cur_ff.mcfg[b][m][MC_CL_LO] & csum[b][m-1];
                end
                if (m == MC_NUM - 1)
                begin : g_last
                    assign hi_c = 1'b0;
                end
                else
                begin : g_hi
                    assign hi_c = cur_ff.mcfg[b][m][MC_CL_LO+2] &
                        csum[b][m+1];
                end
                assign mid_c = cur_ff.mcfg[b][m][MC_CL_LO+1] & csum[b][m];
                assign sum[b][m] = lo_c | mid_c | hi_c;
            end

            plmb_mcell_bank u_mcell (
                .mclk (mclk),
                .rst (rst),
                .sum (sum[b]),
                .mcfg (cur_ff.mcfg[b]),
                .ck_rise (ck_rise),
                .rst_pt (term[b][PT_RESET]),
                .pre_pt (term[b][PT_PRESET]),
                .mc_out (mc_q[b*MC_NUM +: MC_NUM])
            );
        end
    endgenerate

    always_comb
    begin
        nxt_ff = cur_ff;

        // synchronisers for every pin input
        nxt_ff.io_s1 = io_in;
        nxt_ff.io_s2 = cur_ff.io_s1;
        nxt_ff.ded_s1 = ded_in;
        nxt_ff.ded_s2 = cur_ff.ded_s1;
        nxt_ff.ck_s1 = gclk_in;
        nxt_ff.ck_s2 = cur_ff.ck_s1;
        nxt_ff.ck_prev = cur_ff.ck_s2;

        // pin drivers, bank chosen by the cell's position in its block
        for (int bb = 0; bb < BLK_NUM; bb++)
        begin
            for (int mm = 0; mm < MC_NUM; mm++)
            begin
                logic [1:0] mode;
                logic gate;
                mode = cur_ff.mcfg[bb][mm][MC_OE_LO +: 2];
                gate = term[bb][PT_OE_BASE + (mm / BANK_SZ) * OE_PER_BANK +
                    int'(cur_ff.mcfg[bb][mm][MC_OE_SEL])];
                unique case (mode)
                    PLMB_OE_ON:
                        nxt_ff.oe[bb*MC_NUM+mm] = 1'b1;
                    PLMB_OE_PT:
                        nxt_ff.oe[bb*MC_NUM+mm] = gate;
                    default:
                        nxt_ff.oe[bb*MC_NUM+mm] = 1'b0;
                endcase
            end
        end

        // configuration writes
        if (cfg_wr && !cfg_addr[STAT_BIT])
        begin
            if (idx < ROUTE_OFS)
            begin
                if (idx[0])
                    nxt_ff.term[blk][tidx][TERM_W-1:TERM_LO_W] =
                        cfg_wdata[TERM_W-TERM_LO_W-1:0];
                else
                    nxt_ff.term[blk][tidx][TERM_LO_W-1:0] = cfg_wdata;
            end
            else if (idx < MCFG_OFS)
                nxt_ff.route[blk][ridx] = cfg_wdata[SEL_W-1:0];
            else if (idx < MCFG_END)
                nxt_ff.mcfg[blk][midx] = cfg_wdata[MCW-1:0];
        end

        // read data stand only in the cycle after the strobe
        nxt_ff.rdata = '0;
        if (cfg_rd)
        begin
            if (cfg_addr[STAT_BIT])
            begin
                if (idx == STAT_PIN)
                    nxt_ff.rdata = {cur_ff.io_s2[blk*MC_NUM +: MC_NUM],
                        mc_q[blk*MC_NUM +: MC_NUM]};
                else if (idx == STAT_SPT)
                    nxt_ff.rdata = {cur_ff.oe[blk*MC_NUM +: MC_NUM],
                        10'h000, term[blk][PT_NUM-1:LT_NUM]};
            end
            else if (idx < ROUTE_OFS)
            begin
                if (idx[0])
                    nxt_ff.rdata = {12'h000,
                        cur_ff.term[blk][tidx][TERM_W-1:TERM_LO_W]};
                else
                    nxt_ff.rdata = cur_ff.term[blk][tidx][TERM_LO_W-1:0];
            end
            else if (idx < MCFG_OFS)
                nxt_ff.rdata = {24'h000000, cur_ff.route[blk][ridx]};
            else if (idx < MCFG_END)
                nxt_ff.rdata = {21'h000000, cur_ff.mcfg[blk][midx]};
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cur_ff <= '0;
            cur_ff.term <= {(BLK_NUM*PT_NUM){TERM_RST}};
            cur_ff.route <= {(BLK_NUM*IN_NUM){ROUTE_RST}};
            cur_ff.mcfg <= {(BLK_NUM*MC_NUM){MCFG_RST}};
        end
        else
            cur_ff <= nxt_ff;
    end

    assign cfg_rdata = cur_ff.rdata;
    assign io_out = mc_q;
    assign io_oe = cur_ff.oe;

endmodule : plmb_top

// ### tb/plmb_props.sv
module plmb_props
    import plmb_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // configuration port
    input wire logic [ADDR_W-1:0] cfg_addr,
    input wire logic [DATA_W-1:0] cfg_wdata,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [DATA_W-1:0] cfg_rdata,
    // pins
    input wire logic [IO_NUM-1:0] io_in,
    input wire logic [IO_NUM-1:0] io_out,
    input wire logic [IO_NUM-1:0] io_oe,
    input wire logic [DED_NUM-1:0] ded_in,
    input wire logic [CLK_NUM-1:0] gclk_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr_seen_ff;
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            wr_seen_ff <= 1'b0;
        else if (cfg_wr)
            wr_seen_ff <= 1'b1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_wr(logic [7:0] lo, logic [7:0] hi);
        cfg_wr && !cfg_addr[STAT_BIT] && cfg_addr[7:0] >= lo
            && cfg_addr[7:0] < hi;
    endsequence
    sequence s_rd_same;
        cfg_rd && $stable(cfg_addr);
    endsequence
    // the bench leaves one idle cycle between a write and the next strobe
    sequence s_gap;
        !cfg_wr && !cfg_rd && $stable(cfg_addr);
    endsequence
    a_rdata_idle:
        assert property (!$past(cfg_rd) |-> cfg_rdata == '0)
        else $error("read data outside its slot");
    a_rst_clear:
        assert property (disable iff (1'b0) rst |-> io_out == '0
            && io_oe == '0 && cfg_rdata == '0)
        else $error("outputs not cleared in reset");
    a_bad_read:
        assert property (cfg_rd && !cfg_addr[STAT_BIT]
            && cfg_addr[7:0] >= MCFG_END |=> cfg_rdata == '0)
        else $error("unmapped read not zero");
    a_mcfg_back:
        assert property (s_wr(MCFG_OFS, MCFG_END) ##1 s_gap ##1
            s_rd_same |=> cfg_rdata[MCW-1:0] ==
            $past(cfg_wdata[MCW-1:0], 3))
        else $error("macrocell setting readback wrong");
    a_route_back:
        assert property (s_wr(ROUTE_OFS, MCFG_OFS) ##1 s_gap ##1
            s_rd_same |=> cfg_rdata[SEL_W-1:0] ==
            $past(cfg_wdata[SEL_W-1:0], 3))
        else $error("route readback wrong");
    a_stat_oe:
        assert property (cfg_rd && cfg_addr == 11'h401 |=>
            $changed(io_oe[15:0]) || cfg_rdata[31:16] == io_oe[15:0])
        else $error("status enables differ from pins");
    a_stat_mc:
        assert property (cfg_rd && cfg_addr == 11'h400 |=>
            $changed(io_out[15:0]) || cfg_rdata[15:0] == io_out[15:0])
        else $error("status feedback differs from pins");
    a_quiet_out:
        assert property (!wr_seen_ff |-> io_out == '0 && io_oe == '0)
        else $error("activity before any setting");
    a_hold_out:
        assert property ((!cfg_wr && $stable(io_in) && $stable(ded_in)
            && $stable(gclk_in))[*5] |=> $stable(io_out))
        else $error("output moved with quiet inputs");
endmodule : plmb_props

// ### tb/plmb_board.sv
module plmb_board
    import plmb_pkg::*;
(
    // device side
    input wire logic [IO_NUM-1:0] io_out,
    input wire logic [IO_NUM-1:0] io_oe,
    // board drivers
    input wire logic [IO_NUM-1:0] brd_val,
    input wire logic [IO_NUM-1:0] brd_en,
    // resolved pin levels
    output logic [IO_NUM-1:0] io_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // undriven pins float high through board pull-ups
    always_comb
    begin
        for (int i = 0; i < IO_NUM; i++)
        begin
            if (io_oe[i])
                io_in[i] = io_out[i];
            else if (brd_en[i])
                io_in[i] = brd_val[i];
            else
                io_in[i] = 1'b1;
        end
    end
endmodule : plmb_board

// ### tb/tb_programmable_macrocell_logic_block.sv
module tb_programmable_macrocell_logic_block
    import plmb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst;
    logic [ADDR_W-1:0] cfg_addr = '0;
    logic [DATA_W-1:0] cfg_wdata = '0;
    logic cfg_wr = 1'b0;
    logic cfg_rd = 1'b0;
    logic [DATA_W-1:0] cfg_rdata;
    logic [IO_NUM-1:0] io_in, io_out, io_oe;
    logic [IO_NUM-1:0] brd_val = '0;
    logic [IO_NUM-1:0] brd_en = '0;
    logic [DED_NUM-1:0] ded_in = '0;
    logic [CLK_NUM-1:0] gclk_in = '0;
    int miscompares = 0;
    int cmp_count = 0;

    always #4 mclk = ~mclk;

    plmb_top dut (.mclk, .rst, .cfg_addr, .cfg_wdata, .cfg_wr, .cfg_rd,
        .cfg_rdata, .io_in, .io_out, .io_oe, .ded_in, .gclk_in);
    plmb_board u_board (.io_out, .io_oe, .brd_val, .brd_en, .io_in);

    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [DATA_W-1:0] got,
        input logic [DATA_W-1:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [ADDR_W-1:0] ad(input logic [1:0] b,
        input logic [7:0] i);
        return {1'b0, b, i};
    endfunction : ad

    // a gap cycle keeps strobes from being driven twice in one step
    task automatic wr(input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d);
        cfg_addr <= a;
        cfg_wdata <= d;
        cfg_wr <= 1'b1;
        @(posedge mclk);
        cfg_wr <= 1'b0;
        @(posedge mclk);
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] exp);
        cfg_addr <= a;
        cfg_rd <= 1'b1;
        @(posedge mclk);
        cfg_rd <= 1'b0;
        #1 chk(cfg_rdata, exp);
        @(posedge mclk);
    endtask : rd

    task automatic term(input logic [1:0] b, input logic [6:0] t,
        input logic [TERM_W-1:0] m);
        wr(ad(b, {t, 1'b0}), m[31:0]);
        wr(ad(b, {t, 1'b1}), {12'h000, m[51:32]});
    endtask : term

    // pin sync plus macrocell stage, with margin
    task automatic settle;
        repeat (5) @(posedge mclk);
        #1;
    endtask : settle

    task automatic pulse(input int k);
        gclk_in[k] <= 1'b1;
        repeat (3) @(posedge mclk);
        gclk_in[k] <= 1'b0;
        settle;
    endtask : pulse

    initial
    begin
        // x to 1 at time zero gives the flops a real reset edge
        rst <= 1'b1;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(ad(2'h2, 8'h8D), 32'h0000_00FF);
        wr(ad(2'h2, ROUTE_OFS), 32'h0000_0085);
        rd(ad(2'h2, ROUTE_OFS), 32'h0000_0085);
        rd(ad(2'h2, MCFG_END), 32'h0);
        wr(ad(2'h0, ROUTE_OFS), 32'h0000_0080);
        wr(ad(2'h0, 8'h8D), 32'h0000_0081);
        term(2'h0, 7'h00, 52'h1);
        wr(ad(2'h0, MCFG_OFS), 32'h0000_0102);
        wr(ad(2'h0, 8'hA7), 32'h0000_0101);
        ded_in <= 2'b01;
        settle;
        chk(io_out[1:0], 2'b11);
        chk(io_oe[1:0], 2'b11);
        wr(ad(2'h0, MCFG_OFS), 32'h0000_0122);
        settle;
        chk(io_out[0], 1'b0);
        wr(ad(2'h1, ROUTE_OFS), 32'h0);
        term(2'h1, 7'h00, 52'h1);
        wr(ad(2'h1, MCFG_OFS), 32'h0000_0002);
        settle;
        chk(io_out[16], 1'b0);
        wr(ad(2'h0, MCFG_OFS), 32'h0000_0022);
        brd_en[0] <= 1'b1;
        brd_val[0] <= 1'b1;
        settle;
        chk(io_oe[0], 1'b0);
        chk(io_out[16], 1'b1);
        chk(io_out[0], 1'b0);
        term(2'h0, 7'h08, 52'h1);
        wr(ad(2'h0, 8'hA8), 32'h0000_014A);
        settle;
        chk(io_out[2], 1'b0);
        pulse(0);
        chk(io_out[2], 1'b0);
        pulse(1);
        chk(io_out[2], 1'b1);
        // block 1 input 1 routed from macrocell feedback of block 0 cell 2
        wr(ad(2'h1, 8'h8D), 32'h0000_0042);
        term(2'h1, 7'h04, 52'h4);
        wr(ad(2'h1, 8'hA7), 32'h0000_0002);
        settle;
        chk(io_out[17], 1'b1);
        term(2'h0, 7'h0C, 52'h1);
        wr(ad(2'h0, 8'hA9), 32'h0000_015A);
        rd(ad(2'h0, 8'hA9), 32'h0000_015A);
        pulse(1);
        chk(io_out[3], 1'b1);
        pulse(1);
        chk(io_out[3:2], 2'b01);
        term(2'h0, 7'h45, 52'h4);
        ded_in <= 2'b11;
        settle;
        chk(io_out[3:2], 2'b11);
        term(2'h0, 7'h44, 52'h4);
        settle;
        chk(io_out[3:2], 2'b00);
        wr(ad(2'h0, 8'hAE), 32'h0000_0602);
        term(2'h0, 7'h43, 52'h1);
        settle;
        chk(io_oe[8], 1'b1);
        ded_in <= 2'b10;
        settle;
        chk(io_oe[8], 1'b0);
        rd(11'h401, 32'h000E_0030);
        // pin 0 held high by the board, cell 0 inverts a false sum
        rd(11'h400, {16'hFFF1, 16'h0001});
        end_sim;
    end

    initial
    begin
        #30us;
        miscompares++;
        $display("ERROR %0t: run did not finish", $time);
        end_sim;
    end
endmodule : tb_programmable_macrocell_logic_block

bind plmb_top plmb_props u_props (.mclk, .rst, .cfg_addr, .cfg_wdata,
    .cfg_wr, .cfg_rd, .cfg_rdata, .io_in, .io_out, .io_oe, .ded_in,
    .gclk_in);
